/* design/tlr_defs.svh */
`ifndef TLR_DEFS_SVH
`define TLR_DEFS_SVH

// ==========================================
// table geometry and addressing
`define TLR_ENTRIES 36
`define TLR_LAST_INDEX 6'h23
`define TLR_TABLE_BASE 8'h80
`define TLR_TABLE_LAST 8'ha3
`define TLR_RSVD_FIRST 8'ha4
`define TLR_RSVD_LAST 8'ha7
`define TLR_AUX_SLAVE 8'ha0
`define TLR_SEL_FIRST_TABLE 8'h07
`define TLR_SEL_SECOND_TABLE 8'h08
`define TLR_SEL_CONTROL 8'h02

// ==========================================
// set point register pairs
`define TLR_SP1_HI 8'h84
`define TLR_SP1_LO 8'h85
`define TLR_SP2_HI 8'h86
`define TLR_SP2_LO 8'h87

// ==========================================
// temperature index
`define TLR_TEMP_BIAS 9'h028
`define TLR_STEP_SHIFT 2

// ==========================================
// reset values
`define TLR_FACTORY_BYTE 8'h00
`define TLR_SETPOINT_RST 9'h000
`define TLR_INDEX_RST 6'h00

`endif

/* design/tlr_pkg.sv */
package tlr_pkg;
  typedef enum logic [2:0] {
    SPACE_NONE,
    SPACE_AUX,
    SPACE_TABLE1,
    SPACE_TABLE2,
    SPACE_RSVD,
    SPACE_SETPOINT
  } tlr_space_e;
  typedef logic [5:0] tlr_index_t;
  typedef logic [8:0] tlr_setpoint_t;
endpackage

/* design/tlr_channel.sv */
`timescale 1ns/1ns
`include "tlr_defs.svh"

module tlr_channel
  import tlr_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // recall control
  input wire logic i_recall,
  input wire tlr_index_t i_index,
  input wire logic i_manual,
  input wire logic i_align_upper,
  // table access
  input wire logic i_tbl_we,
  input wire tlr_index_t i_tbl_addr,
  input wire logic [7:0] i_tbl_wdata,
  output logic [7:0] o_tbl_rdata,
  // direct set point writes
  input wire logic i_sp_we_hi,
  input wire logic i_sp_we_lo,
  input wire logic [7:0] i_sp_wdata,
  output tlr_setpoint_t o_setpoint
);

  // ==========================================
  // table storage
  logic [7:0] table_ff [`TLR_ENTRIES];
  logic [7:0] entry;
  tlr_setpoint_t setpoint_ff;
  tlr_setpoint_t nxt_setpoint;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < `TLR_ENTRIES; k++) begin
        table_ff[k] <= `TLR_FACTORY_BYTE;
      end
    end else if (i_tbl_we) begin
      table_ff[i_tbl_addr] <= i_tbl_wdata;
    end
  end

  assign o_tbl_rdata = table_ff[i_tbl_addr];
  assign entry = table_ff[i_index];

  // ==========================================
  // set point: recall or direct write
  always_comb begin
    nxt_setpoint = setpoint_ff;
    if (i_manual) begin
      // recall frozen so calibration values stick
      if (i_sp_we_hi) begin
        nxt_setpoint[8] = i_sp_wdata[0];
      end
      if (i_sp_we_lo) begin
        nxt_setpoint[7:0] = i_sp_wdata;
      end
    end else if (i_recall) begin
      // placement of the byte in the 9-bit value
      if (i_align_upper) begin
        nxt_setpoint = {entry, 1'b0};
      end else begin
        nxt_setpoint = {1'b0, entry};
      end
    end
  end

  // value holds between conversions
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      setpoint_ff <= `TLR_SETPOINT_RST;
    end else begin
      setpoint_ff <= nxt_setpoint;
    end
  end

  assign o_setpoint = setpoint_ff;

endmodule

/* design/tlr_top.sv */
`timescale 1ns/1ns
`include "tlr_defs.svh"

// Notes on behaviour
// - table index from temperature, 4 degree steps from -40, first entry at 80h
// - 80h covers -40 to -36, 81h -36 to -32, and onward per 4 degrees
// - each conversion outside first manual mode copies the first table entry into the first set point
// - each conversion outside second manual mode copies the second table entry into the second set point
// - first manual select stops its recall and allows direct set point writes
// - second manual select stops its recall and allows direct set point writes
// - first alignment bit puts the byte in upper or lower set point bits
// - second alignment bit puts the byte in upper or lower set point bits
// - table reads need master level, or user level with write or read grant
// - table writes need master level, or user level with write grant
// - offsets A4h to A7h after each table are reserved, reading zero
// - 256 auxiliary bytes at slave address A0h, factory content zero
// - aux reads need master or user with a grant; writes master or user plus write grant
module tlr_top
  import tlr_pkg::*;
(
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  // temperature conversion result
  input wire logic I_TEMP_DONE,
  input wire logic signed [7:0] I_TEMP_C,
  // output mode bits
  input wire logic I_FIRST_OUTPUT_MANUAL_SELECT,
  input wire logic I_SECOND_OUTPUT_MANUAL_SELECT,
  input wire logic I_FIRST_OUTPUT_BYTE_ALIGNMENT,
  input wire logic I_SECOND_OUTPUT_BYTE_ALIGNMENT,
  // password levels and grants
  input wire logic I_USER_PASSWORD_LEVEL,
  input wire logic I_MASTER_PASSWORD_LEVEL,
  input wire logic I_OUTPUT_TABLES_WRITE_GRANT,
  input wire logic I_OUTPUT_TABLES_READ_GRANT,
  input wire logic I_AUX_MEMORY_WRITE_GRANT,
  input wire logic I_AUX_MEMORY_READ_GRANT,
  // byte access from the bus slave engine
  input wire logic I_ACC_REQ,
  input wire logic I_ACC_WE,
  input wire logic [7:0] I_ACC_SLAVE,
  input wire logic [7:0] I_ACC_TABLE,
  input wire logic [7:0] I_ACC_OFFSET,
  input wire logic [7:0] I_ACC_WDATA,
  output logic O_ACC_ACK,
  output logic [7:0] O_ACC_RDATA,
  output logic O_ACC_DENIED,
  // set points and index
  output logic [5:0] O_TEMPERATURE_TABLE_INDEX,
  output logic [8:0] O_FIRST_OUTPUT_SETPOINT,
  output logic [8:0] O_SECOND_OUTPUT_SETPOINT
);

  // all inputs come from same-clock logic, so no synchronisers

  // ==========================================
  // temperature to table index
  logic [8:0] temp_offs;
  tlr_index_t band;
  tlr_index_t index_now;
  tlr_index_t index_ff;

  assign temp_offs = 9'({I_TEMP_C[7], I_TEMP_C}) + `TLR_TEMP_BIAS;
  assign band = temp_offs[7:`TLR_STEP_SHIFT];

  always_comb begin
    index_now = band;
    if (temp_offs[8]) begin
      index_now = 6'h00;
    end else if (band > `TLR_LAST_INDEX) begin
      index_now = `TLR_LAST_INDEX;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      index_ff <= `TLR_INDEX_RST;
    end else if (I_TEMP_DONE) begin
      index_ff <= index_now;
    end
  end

  // ==========================================
  // access decode
  tlr_space_e space;
  tlr_index_t tbl_addr;
  logic in_table;
  logic in_rsvd;

  assign in_table = (I_ACC_OFFSET >= `TLR_TABLE_BASE) && (I_ACC_OFFSET <= `TLR_TABLE_LAST);
  assign in_rsvd = (I_ACC_OFFSET >= `TLR_RSVD_FIRST) && (I_ACC_OFFSET <= `TLR_RSVD_LAST);
  assign tbl_addr = 6'(I_ACC_OFFSET - `TLR_TABLE_BASE);

  always_comb begin
    space = SPACE_NONE;
    if (I_ACC_SLAVE == `TLR_AUX_SLAVE) begin
      space = SPACE_AUX;
    end else if (I_ACC_TABLE == `TLR_SEL_FIRST_TABLE || I_ACC_TABLE == `TLR_SEL_SECOND_TABLE) begin
      if (in_table) begin
        space = (I_ACC_TABLE == `TLR_SEL_FIRST_TABLE) ? SPACE_TABLE1 : SPACE_TABLE2;
      end else if (in_rsvd) begin
        space = SPACE_RSVD;
      end
    end else if (I_ACC_TABLE == `TLR_SEL_CONTROL) begin
      if (I_ACC_OFFSET >= `TLR_SP1_HI && I_ACC_OFFSET <= `TLR_SP2_LO) begin
        space = SPACE_SETPOINT;
      end
    end
  end

  // ==========================================
  // password gating
  logic tbl_rd_ok;
  logic tbl_wr_ok;
  logic aux_rd_ok;
  logic aux_wr_ok;
  logic allowed;
  logic do_write;
  logic manual_hit;

  assign tbl_rd_ok = I_MASTER_PASSWORD_LEVEL |
                     (I_USER_PASSWORD_LEVEL & (I_OUTPUT_TABLES_WRITE_GRANT | I_OUTPUT_TABLES_READ_GRANT));
  assign tbl_wr_ok = I_MASTER_PASSWORD_LEVEL | (I_USER_PASSWORD_LEVEL & I_OUTPUT_TABLES_WRITE_GRANT);
  assign aux_rd_ok = I_MASTER_PASSWORD_LEVEL |
                     (I_USER_PASSWORD_LEVEL & (I_AUX_MEMORY_WRITE_GRANT | I_AUX_MEMORY_READ_GRANT));
  assign aux_wr_ok = I_MASTER_PASSWORD_LEVEL | (I_USER_PASSWORD_LEVEL & I_AUX_MEMORY_WRITE_GRANT);

  // set point writes only land while that output is in manual mode
  assign manual_hit = (I_ACC_OFFSET <= `TLR_SP1_LO) ? I_FIRST_OUTPUT_MANUAL_SELECT : I_SECOND_OUTPUT_MANUAL_SELECT;

  always_comb begin
    case (space)
      SPACE_AUX: begin
        allowed = I_ACC_WE ? aux_wr_ok : aux_rd_ok;
      end
      SPACE_TABLE1, SPACE_TABLE2, SPACE_RSVD: begin
        allowed = I_ACC_WE ? tbl_wr_ok : tbl_rd_ok;
      end
      SPACE_SETPOINT: begin
        allowed = I_ACC_WE ? manual_hit : 1'b1;
      end
      default: begin
        allowed = 1'b1;
      end
    endcase
  end

  assign do_write = I_ACC_REQ & I_ACC_WE & allowed;

  // ==========================================
  // auxiliary memory
  logic [7:0] aux_mem_ff [256];

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      for (int k = 0; k < 256; k++) begin
        aux_mem_ff[k] <= `TLR_FACTORY_BYTE;
      end
    end else if (do_write && space == SPACE_AUX) begin
      aux_mem_ff[I_ACC_OFFSET] <= I_ACC_WDATA;
    end
  end

  // ==========================================
  // output channels
  logic [7:0] tbl1_rdata;
  logic [7:0] tbl2_rdata;
  tlr_setpoint_t sp1;
  tlr_setpoint_t sp2;
  logic sp_space_we;

  assign sp_space_we = do_write && space == SPACE_SETPOINT;

  tlr_channel u_first (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .i_recall(I_TEMP_DONE),
    .i_index(index_now),
    .i_manual(I_FIRST_OUTPUT_MANUAL_SELECT),
    .i_align_upper(I_FIRST_OUTPUT_BYTE_ALIGNMENT),
    .i_tbl_we(do_write && space == SPACE_TABLE1),
    .i_tbl_addr(tbl_addr),
    .i_tbl_wdata(I_ACC_WDATA),
    .o_tbl_rdata(tbl1_rdata),
    .i_sp_we_hi(sp_space_we && I_ACC_OFFSET == `TLR_SP1_HI),
    .i_sp_we_lo(sp_space_we && I_ACC_OFFSET == `TLR_SP1_LO),
    .i_sp_wdata(I_ACC_WDATA),
    .o_setpoint(sp1)
  );

  tlr_channel u_second (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .i_recall(I_TEMP_DONE),
    .i_index(index_now),
    .i_manual(I_SECOND_OUTPUT_MANUAL_SELECT),
    .i_align_upper(I_SECOND_OUTPUT_BYTE_ALIGNMENT),
    .i_tbl_we(do_write && space == SPACE_TABLE2),
    .i_tbl_addr(tbl_addr),
    .i_tbl_wdata(I_ACC_WDATA),
    .o_tbl_rdata(tbl2_rdata),
    .i_sp_we_hi(sp_space_we && I_ACC_OFFSET == `TLR_SP2_HI),
    .i_sp_we_lo(sp_space_we && I_ACC_OFFSET == `TLR_SP2_LO),
    .i_sp_wdata(I_ACC_WDATA),
    .o_setpoint(sp2)
  );

  // ==========================================
  // read data and answer
  logic [7:0] rd_mux;
  logic ack_ff;
  logic denied_ff;
  logic [7:0] rdata_ff;

  always_comb begin
    rd_mux = 8'h00;
    case (space)
      SPACE_AUX: begin
        rd_mux = aux_mem_ff[I_ACC_OFFSET];
      end
      SPACE_TABLE1: begin
        rd_mux = tbl1_rdata;
      end
      SPACE_TABLE2: begin
        rd_mux = tbl2_rdata;
      end
      SPACE_SETPOINT: begin
        case (I_ACC_OFFSET)
          `TLR_SP1_HI: rd_mux = {7'h00, sp1[8]};
          `TLR_SP1_LO: rd_mux = sp1[7:0];
          `TLR_SP2_HI: rd_mux = {7'h00, sp2[8]};
          default: rd_mux = sp2[7:0];
        endcase
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // refused reads return zero rather than stale data
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ack_ff <= 1'b0;
      denied_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      ack_ff <= I_ACC_REQ;
      denied_ff <= I_ACC_REQ & ~allowed;
      if (I_ACC_REQ) begin
        rdata_ff <= (allowed && !I_ACC_WE) ? rd_mux : 8'h00;
      end
    end
  end

  assign O_ACC_ACK = ack_ff;
  assign O_ACC_DENIED = denied_ff;
  assign O_ACC_RDATA = rdata_ff;
  assign O_TEMPERATURE_TABLE_INDEX = index_ff;
  assign O_FIRST_OUTPUT_SETPOINT = sp1;
  assign O_SECOND_OUTPUT_SETPOINT = sp2;

endmodule

/* test/tlr_top_checker.sv */
`timescale 1ns/1ns
// ==========================================
// port checks for the recall block
module tlr_top_checker (
  input wire logic I_CLK_SYS, I_SYS_RST, I_TEMP_DONE, I_ACC_REQ, I_ACC_WE,
  input wire logic signed [7:0] I_TEMP_C,
  input wire logic I_FIRST_OUTPUT_MANUAL_SELECT, I_SECOND_OUTPUT_MANUAL_SELECT,
  input wire logic I_USER_PASSWORD_LEVEL, I_MASTER_PASSWORD_LEVEL, I_OUTPUT_TABLES_WRITE_GRANT,
  input wire logic I_OUTPUT_TABLES_READ_GRANT, I_AUX_MEMORY_WRITE_GRANT, I_AUX_MEMORY_READ_GRANT,
  input wire logic [7:0] I_ACC_SLAVE, I_ACC_TABLE, I_ACC_OFFSET,
  input wire logic O_ACC_ACK, O_ACC_DENIED,
  input wire logic [7:0] O_ACC_RDATA,
  input wire logic [5:0] O_TEMPERATURE_TABLE_INDEX,
  input wire logic [8:0] O_FIRST_OUTPUT_SETPOINT, O_SECOND_OUTPUT_SETPOINT
);
  wire u = I_USER_PASSWORD_LEVEL;
  wire m = I_MASTER_PASSWORD_LEVEL;
  wire aux = I_ACC_REQ && I_ACC_SLAVE == 8'ha0;
  wire tbl = I_ACC_REQ && !aux && (I_ACC_TABLE == 8'h07 || I_ACC_TABLE == 8'h08) &&
    I_ACC_OFFSET >= 8'h80 && I_ACC_OFFSET <= 8'ha7;
  wire [8:0] t9 = {I_TEMP_C[7], I_TEMP_C} + 9'h028;
  // out of range folds onto the end entries, sign picks which
  wire [5:0] idx = (t9 < 9'h090) ? t9[7:2] : (I_TEMP_C < 0 ? 6'h00 : 6'h23);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);
  property p_ack; I_ACC_REQ |=> O_ACC_ACK; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_noack; !I_ACC_REQ |=> !O_ACC_ACK; endproperty
  a_noack: assert property (p_noack) else $error("ack without request");
  // gating is judged on the request cycle, not on the answer cycle
  property p_trd; tbl && !I_ACC_WE |=> O_ACC_DENIED == !($past(m) || $past(u) &&
    ($past(I_OUTPUT_TABLES_WRITE_GRANT) || $past(I_OUTPUT_TABLES_READ_GRANT))); endproperty
  a_trd: assert property (p_trd) else $error("table read gating wrong");
  property p_twr; tbl && I_ACC_WE |=> O_ACC_DENIED == !($past(m) || $past(u) &&
    $past(I_OUTPUT_TABLES_WRITE_GRANT)); endproperty
  a_twr: assert property (p_twr) else $error("table write gating wrong");
  property p_aux; aux |=> O_ACC_DENIED == !($past(m) || $past(u) && ($past(I_AUX_MEMORY_WRITE_GRANT) ||
    !$past(I_ACC_WE) && $past(I_AUX_MEMORY_READ_GRANT))); endproperty
  a_aux: assert property (p_aux) else $error("aux gating wrong");
  property p_dz; O_ACC_DENIED |-> O_ACC_ACK && O_ACC_RDATA == 8'h00; endproperty
  a_dz: assert property (p_dz) else $error("refused access leaked data");
  property p_idx; I_TEMP_DONE |=> O_TEMPERATURE_TABLE_INDEX == $past(idx); endproperty
  a_idx: assert property (p_idx) else $error("table index wrong");
  property p_ihold; !I_TEMP_DONE |=> $stable(O_TEMPERATURE_TABLE_INDEX); endproperty
  a_ihold: assert property (p_ihold) else $error("index moved without conversion");
  property p_m1; I_FIRST_OUTPUT_MANUAL_SELECT && !I_ACC_REQ |=> $stable(O_FIRST_OUTPUT_SETPOINT); endproperty
  a_m1: assert property (p_m1) else $error("first manual set point moved");
  property p_m2; I_SECOND_OUTPUT_MANUAL_SELECT && !I_ACC_REQ |=> $stable(O_SECOND_OUTPUT_SETPOINT); endproperty
  a_m2: assert property (p_m2) else $error("second manual set point moved");
  property p_h1; !I_FIRST_OUTPUT_MANUAL_SELECT && !I_TEMP_DONE |=> $stable(O_FIRST_OUTPUT_SETPOINT); endproperty
  a_h1: assert property (p_h1) else $error("first set point moved between conversions");
  property p_h2; !I_SECOND_OUTPUT_MANUAL_SELECT && !I_TEMP_DONE |=> $stable(O_SECOND_OUTPUT_SETPOINT); endproperty
  a_h2: assert property (p_h2) else $error("second set point moved between conversions");
endmodule

bind tlr_top tlr_top_checker u_chk (.*);

/* test/tlr_host.sv */
`timescale 1ns/1ns
// ==========================================
// host controller issuing byte accesses
module tlr_host (
  input wire logic I_CLK_SYS,
  input wire logic O_ACC_ACK, O_ACC_DENIED,
  input wire logic [7:0] O_ACC_RDATA,
  output logic I_ACC_REQ, I_ACC_WE,
  output logic [7:0] I_ACC_SLAVE, I_ACC_TABLE, I_ACC_OFFSET, I_ACC_WDATA
);
  initial {I_ACC_REQ, I_ACC_WE, I_ACC_SLAVE, I_ACC_TABLE, I_ACC_OFFSET, I_ACC_WDATA} = '0;
  task acc(input logic we, input logic [7:0] sl, tb, of, wd, output logic [7:0] rd, output logic dn, ak);
    @(posedge I_CLK_SYS);
    I_ACC_REQ <= 1'b1;
    I_ACC_WE <= we;
    I_ACC_SLAVE <= sl;
    I_ACC_TABLE <= tb;
    I_ACC_OFFSET <= of;
    I_ACC_WDATA <= wd;
    @(posedge I_CLK_SYS);
    I_ACC_REQ <= 1'b0;
    // released lines must not keep showing the old byte
    I_ACC_OFFSET <= ~of;
    I_ACC_WDATA <= ~wd;
    #1;
    rd = O_ACC_RDATA;
    dn = O_ACC_DENIED;
    ak = O_ACC_ACK;
  endtask
  // same value everywhere keeps the output flat over temperature
  task fill(input logic [7:0] tb, v);
    logic [7:0] rd;
    logic dn, ak;
    for (int i = 0; i < 36; i++) begin
      acc(1'b1, 8'ha2, tb, 8'h80 + i[7:0], v, rd, dn, ak);
    end
  endtask
endmodule

/* test/tlr_top_tb.sv */
`timescale 1ns/1ns
// ==========================================
// bench for the recall block
module tlr_top_tb;
  logic I_CLK_SYS = 0, I_SYS_RST = 1, I_TEMP_DONE = 0;
  logic signed [7:0] I_TEMP_C = 8'h00;
  logic I_FIRST_OUTPUT_MANUAL_SELECT = 0, I_SECOND_OUTPUT_MANUAL_SELECT = 0;
  logic I_FIRST_OUTPUT_BYTE_ALIGNMENT = 0, I_SECOND_OUTPUT_BYTE_ALIGNMENT = 0;
  logic I_USER_PASSWORD_LEVEL = 0, I_MASTER_PASSWORD_LEVEL = 0, I_OUTPUT_TABLES_WRITE_GRANT = 0;
  logic I_OUTPUT_TABLES_READ_GRANT = 0, I_AUX_MEMORY_WRITE_GRANT = 0, I_AUX_MEMORY_READ_GRANT = 0;
  logic I_ACC_REQ, I_ACC_WE, O_ACC_ACK, O_ACC_DENIED;
  logic [7:0] I_ACC_SLAVE, I_ACC_TABLE, I_ACC_OFFSET, I_ACC_WDATA, O_ACC_RDATA;
  logic [5:0] O_TEMPERATURE_TABLE_INDEX;
  logic [8:0] O_FIRST_OUTPUT_SETPOINT, O_SECOND_OUTPUT_SETPOINT;
  int n_errors = 0, num_checks = 0;
  tlr_top dut (.*);
  tlr_host host (.*);
  always #2 I_CLK_SYS = ~I_CLK_SYS;
  // ==========================================
  // helpers
  task chk(input logic [8:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task lv(input logic [5:0] v);
    @(posedge I_CLK_SYS);
    {I_USER_PASSWORD_LEVEL, I_MASTER_PASSWORD_LEVEL, I_OUTPUT_TABLES_WRITE_GRANT, I_OUTPUT_TABLES_READ_GRANT,
      I_AUX_MEMORY_WRITE_GRANT, I_AUX_MEMORY_READ_GRANT} <= v;
  endtask
  task xa(input logic we, input logic [7:0] sl, tb, of, wd, ed, input logic edn);
    logic [7:0] rd;
    logic dn, ak;
    host.acc(we, sl, tb, of, wd, rd, dn, ak);
    chk(ak, 1, "ack");
    chk(dn, edn, "refusal");
    if (!we) begin
      chk(rd, ed, "read data");
    end
  endtask
  task tc(input logic signed [7:0] t, input logic [5:0] ix, input logic [8:0] s1, s2);
    @(posedge I_CLK_SYS);
    I_TEMP_DONE <= 1'b1;
    I_TEMP_C <= t;
    @(posedge I_CLK_SYS);
    I_TEMP_DONE <= 1'b0;
    I_TEMP_C <= ~t;
    #1;
    chk(O_TEMPERATURE_TABLE_INDEX, ix, "index");
    chk(O_FIRST_OUTPUT_SETPOINT, s1, "first set point");
    chk(O_SECOND_OUTPUT_SETPOINT, s2, "second set point");
  endtask
  // ==========================================
  // scenarios
  task t_reset;
    chk(O_FIRST_OUTPUT_SETPOINT | O_SECOND_OUTPUT_SETPOINT, 0, "set points after reset");
    lv(6'h10);
    xa(0, 8'ha2, 8'h07, 8'h80, 8'h00, 8'h00, 0);
    xa(1, 8'ha2, 8'h08, 8'ha4, 8'h55, 8'h00, 0);
    xa(0, 8'ha2, 8'h08, 8'ha4, 8'h00, 8'h00, 0);
    xa(0, 8'ha0, 8'h00, 8'hff, 8'h00, 8'h00, 0);
    xa(0, 8'ha2, 8'h07, 8'ha5, 8'h00, 8'h00, 0);
    // main memory write must not reach the aux bytes at the same offset
    xa(1, 8'ha2, 8'h05, 8'h10, 8'h77, 8'h00, 0);
    xa(0, 8'ha0, 8'h00, 8'h10, 8'h00, 8'h00, 0);
    xa(0, 8'ha2, 8'h05, 8'h10, 8'h00, 8'h00, 0);
    // offset below the table must not wrap onto an entry
    xa(1, 8'ha2, 8'h07, 8'h10, 8'h99, 8'h00, 0);
    xa(0, 8'ha2, 8'h07, 8'h90, 8'h00, 8'h00, 0);
    xa(1, 8'ha2, 8'h08, 8'h82, 8'h66, 8'h00, 0);
    xa(0, 8'ha2, 8'h08, 8'h82, 8'h00, 8'h66, 0);
    $display("done reset");
  endtask
  task t_gate;
    logic u, m, w, r, ok;
    logic [7:0] lt, la;
    lt = 8'h00;
    la = 8'h00;
    for (int v = 0; v < 16; v++) begin
      {u, m, w, r} = v[3:0];
      lv({u, m, w, r, w, r});
      xa(1, 8'ha2, 8'h07, 8'h90, v[7:0] + 8'h40, 8'h00, !(m | u & w));
      if (m | u & w) lt = v[7:0] + 8'h40;
      ok = m | u & (w | r);
      xa(0, 8'ha2, 8'h07, 8'h90, 8'h00, ok ? lt : 8'h00, !ok);
      xa(1, 8'ha0, 8'h00, 8'h10, v[7:0] + 8'h40, 8'h00, !(m | u & w));
      if (m | u & w) la = v[7:0] + 8'h40;
      xa(0, 8'ha0, 8'h00, 8'h10, 8'h00, ok ? la : 8'h00, !ok);
    end
    $display("done gate");
  endtask
  task t_recall;
    lv(6'h10);
    host.fill(8'h08, 8'h3c);
    xa(1, 8'ha2, 8'h07, 8'h80, 8'h5a, 8'h00, 0);
    xa(1, 8'ha2, 8'h07, 8'h81, 8'hc3, 8'h00, 0);
    xa(1, 8'ha2, 8'h07, 8'ha3, 8'h7e, 8'h00, 0);
    @(posedge I_CLK_SYS);
    I_FIRST_OUTPUT_BYTE_ALIGNMENT <= 1'b1;
    tc(-8'sd36, 6'h01, 9'h186, 9'h03c);
    tc(-8'sd41, 6'h00, 9'h0b4, 9'h03c);
    tc(-8'sd128, 6'h00, 9'h0b4, 9'h03c);
    tc(8'sd103, 6'h23, 9'h0fc, 9'h03c);
    tc(8'sd127, 6'h23, 9'h0fc, 9'h03c);
    @(posedge I_CLK_SYS);
    I_FIRST_OUTPUT_BYTE_ALIGNMENT <= 1'b0;
    I_SECOND_OUTPUT_BYTE_ALIGNMENT <= 1'b1;
    tc(-8'sd33, 6'h01, 9'h0c3, 9'h078);
    $display("done recall");
  endtask
  task t_manual;
    @(posedge I_CLK_SYS);
    I_FIRST_OUTPUT_MANUAL_SELECT <= 1'b1;
    tc(-8'sd40, 6'h00, 9'h0c3, 9'h078);
    xa(1, 8'ha2, 8'h02, 8'h84, 8'h01, 8'h00, 0);
    xa(1, 8'ha2, 8'h02, 8'h85, 8'h55, 8'h00, 0);
    xa(0, 8'ha2, 8'h02, 8'h84, 8'h00, 8'h01, 0);
    chk(O_FIRST_OUTPUT_SETPOINT, 9'h155, "manual write");
    xa(1, 8'ha2, 8'h02, 8'h87, 8'h11, 8'h00, 1);
    @(posedge I_CLK_SYS);
    I_SECOND_OUTPUT_MANUAL_SELECT <= 1'b1;
    xa(1, 8'ha2, 8'h02, 8'h87, 8'h11, 8'h00, 0);
    xa(0, 8'ha2, 8'h02, 8'h87, 8'h00, 8'h11, 0);
    xa(0, 8'ha2, 8'h02, 8'h86, 8'h00, 8'h00, 0);
    tc(-8'sd36, 6'h01, 9'h155, 9'h011);
    $display("done manual");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge I_CLK_SYS);
    n_errors++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge I_CLK_SYS);
    I_SYS_RST <= 1'b0;
    t_reset;
    t_gate;
    t_recall;
    t_manual;
    final_report;
  end
endmodule
